// File: shared/bmb_consts.vh
`ifndef BMB_CONSTS_VH
`define BMB_CONSTS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BMB_UCFG_LO 8'h00
`define BMB_UCFG_HI 8'h04
`define BMB_SCFG_LO 8'h08
`define BMB_SCFG_HI 8'h0c
`define BMB_STAT_LO 8'h10
`define BMB_STAT_HI 8'h14
`define BMB_SMM_LO 8'h18
`define BMB_SMM_HI 8'h1c
`define BMB_GST_LO 8'h20
`define BMB_GST_HI 8'h24
`define BMB_CTRL 8'h28
`define BMB_INFO 8'h2c
`define BMB_BND_BASE 8'h40
`define BMB_BND_END 8'h7c
// ----------------------------------------
// config register fields
// ----------------------------------------
`define BMB_CFG_EN 0
`define BMB_CFG_PRES 1
`define BMB_CFG_RSV_LO 2
`define BMB_CFG_RSV_HI 11
`define BMB_CFG_RST 64'h0000000000000000
// ----------------------------------------
// control register fields
// ----------------------------------------
`define BMB_CTL_XCLR 0
`define BMB_CTL_NLOAD 1
`define BMB_CTL_OSX 2
`define BMB_CTL_XBR 3
`define BMB_CTL_XBC 4
`define BMB_CTL_RST 5'h00
// ----------------------------------------
// modes, privilege, save slot, responses
// ----------------------------------------
`define BMB_MODE16 2'h0
`define BMB_MODE32 2'h1
`define BMB_MODE64 2'h2
`define BMB_CPL_USER 2'h3
`define BMB_SMM_SLOT 16'h7ed0
`define BMB_RESP_OK 2'h0
`define BMB_RESP_ERR 2'h2
`endif

// File: verilog/bmb_brdec.v
`timescale 1ns/10ps
`default_nettype none
module bmb_brdec (
	// opcode bytes, first byte first
	input wire [7:0] op0,
	input wire [7:0] op1,
	input wire [7:0] op2,
	// decode result
	output reg covered,
	output reg bnd_pfx
);
	reg [7:0] b0;
	reg [7:0] b1;
	always @* begin
		bnd_pfx = (op0 == 8'hf2); // RULE7
		b0 = bnd_pfx ? op1 : op0;
		b1 = bnd_pfx ? op2 : op1;
		covered = 1'b0;
		// far forms and eb fall through as not covered
		case (b0) // RULE13 RULE8
			8'he8, 8'hc2, 8'hc3, 8'he9: begin
				covered = 1'b1;
			end
			8'hff: begin
				covered = (b1[5:3] == 3'h2) || (b1[5:3] == 3'h4);
			end
			8'h0f: begin
				covered = (b1[7:4] == 4'h8);
			end
			default: begin
				covered = (b0[7:4] == 4'h7);
			end
		endcase
	end
endmodule
`default_nettype wire

// File: verilog/bmb_ctrl.v
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "bmb_consts.vh"
// Function
// (RULE1) 64-bit mode: full-width bounds and addresses
// (RULE2) extended-state moves always use 64 bits
// (RULE3) legacy modes: 32-bit bounds, upper half zeroed
// (RULE4) 32-bit updates may clear upper half
// (RULE5) address size and fault by mode, prefix
// (RULE6) register forms ignore address-size prefix
// (RULE7) f2 before near branch is branch prefix
// (RULE8) far branches and eb never reset
// (RULE9) preserve 0, no prefix: reset four
// (RULE10) preserve 1, no prefix: keep four
// (RULE11) prefixed branch keeps four
// (RULE12) preserve bit 1, chosen by privilege
// (RULE13) covered branch opcode table
// (RULE14) enabled range fault zeroes status
// (RULE15) otherwise range check keeps status
// (RULE16) management entry saves, clears supervisor config
// (RULE17) resume reloads with fixed reserved, canonical
// (RULE18) vm exit always saves supervisor config
// (RULE19) exit clear control clears after save
// (RULE20) entry load control loads guest config
// (RULE21) bad guest config fails entry late
// (RULE22) reset zeroes both bounds same cycle
module bmb_ctrl #(
	parameter LA_BITS = 48
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// core state
	input wire [1:0] cpu_mode,
	input wire [1:0] current_privilege_level,
	// bounds instruction
	input wire bi_valid,
	input wire bi_mem,
	input wire bi_pfx67,
	input wire bi_wr,
	input wire bi_xstate,
	input wire [1:0] bi_idx,
	input wire [63:0] bi_lb,
	input wire [63:0] bi_ub,
	// retiring branch
	input wire br_valid,
	input wire [7:0] br_op0,
	input wire [7:0] br_op1,
	input wire [7:0] br_op2,
	// range check, management, vm events
	input wire rc_fault,
	input wire system_management_interrupt,
	input wire resume_from_management,
	input wire vm_exit,
	input wire vm_entry,
	// results
	output reg ud_fault_r,
	output reg addr64_r,
	output reg bnd_init_r,
	output reg entry_fail_r
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [63:0] ucfg_r;
	reg [63:0] scfg_r;
	reg [63:0] stat_r;
	reg [63:0] smm_r;
	reg [63:0] gst_r;
	reg [4:0] ctl_r;
	reg [63:0] lb_r [0:3];
	reg [63:0] ub_r [0:3];
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg aw_got_r;
	reg w_got_r;
	integer i;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] be;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k]) begin
					merge[k*8 +: 8] = nw[k*8 +: 8];
				end
			end
		end
	endfunction
	function [63:0] put64;
		input [63:0] old;
		input hi;
		input [31:0] nw;
		input [3:0] be;
		begin
			put64 = old;
			if (hi) begin
				put64[63:32] = merge(old[63:32], nw, be);
			end else begin
				put64[31:0] = merge(old[31:0], nw, be);
			end
		end
	endfunction
	function [63:0] cfg_fix;
		input [63:0] v;
		integer k;
		begin
			cfg_fix = v;
			cfg_fix[`BMB_CFG_RSV_HI:`BMB_CFG_RSV_LO] = 10'h000;
			for (k = LA_BITS; k < 64; k = k + 1) begin
				cfg_fix[k] = v[LA_BITS-1];
			end
		end
	endfunction
	function cfg_ok;
		input [63:0] v;
		begin
			cfg_ok = (cfg_fix(v) == v);
		end
	endfunction
	function mapped;
		input [7:0] a;
		begin
			mapped = (a[1:0] == 2'h0) &&
				((a <= `BMB_INFO) ||
				((a >= `BMB_BND_BASE) && (a <= `BMB_BND_END)));
		end
	endfunction
	// ----------------------------------------
	// branch decode and active config
	// ----------------------------------------
	wire br_cov;
	wire br_pfx;
	bmb_brdec u_dec ( // RULE7 RULE8 RULE13
		.op0(br_op0),
		.op1(br_op1),
		.op2(br_op2),
		.covered(br_cov),
		.bnd_pfx(br_pfx)
	);
	wire is_user = (current_privilege_level == `BMB_CPL_USER);
	wire [63:0] act_cfg = is_user ? ucfg_r : scfg_r; // RULE12
	wire act_pres = act_cfg[`BMB_CFG_PRES]; // RULE12
	wire act_en = act_cfg[`BMB_CFG_EN];
	// cleared supervisor config (management entry) disables branch resets at non-user privilege
	wire br_init = br_valid && br_cov && !br_pfx && act_en && !act_pres; // RULE9 RULE10 RULE11 RULE16
	// ----------------------------------------
	// address size and operand width
	// ----------------------------------------
	wire mode64 = (cpu_mode == `BMB_MODE64);
	reg ud_nxt;
	always @* begin
		ud_nxt = 1'b0;
		if (bi_valid && bi_mem && !mode64) begin // RULE6
			if (cpu_mode == `BMB_MODE32) begin
				ud_nxt = bi_pfx67; // RULE5
			end else begin
				ud_nxt = !bi_pfx67; // RULE5
			end
		end
	end
	wire full_w = mode64 || bi_xstate; // RULE1 RULE2
	wire [63:0] wr_lb = full_w ? bi_lb : {32'h0, bi_lb[31:0]}; // RULE3 RULE4
	wire [63:0] wr_ub = full_w ? bi_ub : {32'h0, bi_ub[31:0]}; // RULE3 RULE4
	wire bi_do_wr = bi_valid && bi_wr && !ud_nxt;
	// ----------------------------------------
	// axi write path
	// ----------------------------------------
	wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
	wire wr_hi = awaddr_r[2];
	wire wr_u = wr_go && (awaddr_r[7:3] == `BMB_UCFG_LO >> 3);
	wire wr_s = wr_go && (awaddr_r[7:3] == `BMB_SCFG_LO >> 3);
	wire wr_st = wr_go && (awaddr_r[7:3] == `BMB_STAT_LO >> 3);
	wire wr_sm = wr_go && (awaddr_r[7:3] == `BMB_SMM_LO >> 3);
	wire wr_g = wr_go && (awaddr_r[7:3] == `BMB_GST_LO >> 3);
	wire wr_c = wr_go && (awaddr_r == `BMB_CTRL);
	wire wr_ok = mapped(awaddr_r) && (awaddr_r < `BMB_INFO);
	wire [63:0] s_new = put64(scfg_r, wr_hi, wdata_r, wstrb_r);
	wire [31:0] ctl_new = merge({27'h0, ctl_r}, wdata_r, wstrb_r);
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BMB_RESP_OK;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else begin
			s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `BMB_RESP_OK : `BMB_RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// configuration, save images, status
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			ucfg_r <= `BMB_CFG_RST;
			scfg_r <= `BMB_CFG_RST;
			stat_r <= 64'h0000000000000000;
			smm_r <= 64'h0000000000000000;
			gst_r <= 64'h0000000000000000;
			ctl_r <= `BMB_CTL_RST;
			entry_fail_r <= 1'b0;
		end else begin
			entry_fail_r <= 1'b0;
			if (wr_u) begin
				ucfg_r <= put64(ucfg_r, wr_hi, wdata_r, wstrb_r);
			end
			if (wr_c) begin
				ctl_r <= ctl_new[4:0];
			end
			if (wr_sm) begin
				smm_r <= put64(smm_r, wr_hi, wdata_r, wstrb_r);
			end
			if (system_management_interrupt) begin
				smm_r <= scfg_r; // RULE16
				scfg_r <= `BMB_CFG_RST; // RULE16
			end else if (resume_from_management) begin
				scfg_r <= cfg_fix(smm_r); // RULE17
			end else if (vm_exit) begin
				if (ctl_r[`BMB_CTL_XCLR]) begin
					scfg_r <= `BMB_CFG_RST; // RULE19
				end
			end else if (vm_entry && ctl_r[`BMB_CTL_NLOAD]) begin
				if (cfg_ok(gst_r)) begin
					scfg_r <= gst_r; // RULE20
				end else begin
					entry_fail_r <= 1'b1; // RULE21
				end
			end else if (wr_s && cfg_ok(s_new)) begin
				scfg_r <= s_new;
			end
			if (vm_exit) begin
				gst_r <= scfg_r; // RULE18
			end else if (wr_g) begin
				gst_r <= put64(gst_r, wr_hi, wdata_r, wstrb_r);
			end
			if (rc_fault && ctl_r[`BMB_CTL_OSX] && ctl_r[`BMB_CTL_XBR] &&
				ctl_r[`BMB_CTL_XBC] && act_en) begin
				stat_r <= 64'h0000000000000000; // RULE14
			end else if (wr_st) begin
				stat_r <= put64(stat_r, wr_hi, wdata_r, wstrb_r); // RULE15
			end
		end
	end
	// ----------------------------------------
	// bound registers 0 to 3
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			for (i = 0; i < 4; i = i + 1) begin
				lb_r[i] <= 64'h0000000000000000;
				ub_r[i] <= 64'h0000000000000000;
			end
			ud_fault_r <= 1'b0;
			addr64_r <= 1'b0;
			bnd_init_r <= 1'b0;
		end else begin
			ud_fault_r <= ud_nxt; // RULE5
			if (bi_valid && bi_mem) begin
				addr64_r <= mode64; // RULE1 RULE5
			end
			bnd_init_r <= br_init;
			if (br_init) begin
				for (i = 0; i < 4; i = i + 1) begin
					lb_r[i] <= 64'h0000000000000000; // RULE22
					ub_r[i] <= 64'h0000000000000000; // RULE22
				end
			end else if (bi_do_wr) begin
				lb_r[bi_idx] <= wr_lb;
				ub_r[bi_idx] <= wr_ub;
			end
		end
	end
	// ----------------------------------------
	// axi read path
	// ----------------------------------------
	reg [31:0] rd_nxt;
	reg [63:0] rd64;
	wire [3:0] bidx = s_axi_araddr[5:2];
	always @* begin
		rd64 = 64'h0000000000000000;
		case (s_axi_araddr[7:3])
			`BMB_UCFG_LO >> 3: begin
				rd64 = ucfg_r;
			end
			`BMB_SCFG_LO >> 3: begin
				rd64 = scfg_r;
			end
			`BMB_STAT_LO >> 3: begin
				rd64 = stat_r;
			end
			`BMB_SMM_LO >> 3: begin
				rd64 = smm_r;
			end
			`BMB_GST_LO >> 3: begin
				rd64 = gst_r;
			end
			default: begin
				rd64 = bidx[1] ? ub_r[bidx[3:2]] : lb_r[bidx[3:2]];
			end
		endcase
		rd_nxt = s_axi_araddr[2] ? rd64[63:32] : rd64[31:0];
		if (s_axi_araddr == `BMB_CTRL) begin
			rd_nxt = {27'h0, ctl_r};
		end else if (s_axi_araddr == `BMB_INFO) begin
			rd_nxt = {`BMB_SMM_SLOT, 12'h000, entry_fail_r,
				bnd_init_r, addr64_r, ud_fault_r};
		end else if (!mapped(s_axi_araddr)) begin
			rd_nxt = 32'h00000000;
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `BMB_RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_nxt;
				s_axi_rresp <= mapped(s_axi_araddr) ? `BMB_RESP_OK : `BMB_RESP_ERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: bench/bmb_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module bmb_ctrl_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// core inputs
	input wire logic [1:0] cpu_mode,
	input wire logic bi_valid,
	input wire logic bi_mem,
	input wire logic bi_pfx67,
	input wire logic br_valid,
	input wire logic vm_entry,
	input wire logic [7:0] br_op0,
	input wire logic [7:0] br_op1,
	// results
	input wire logic ud_fault_r,
	input wire logic addr64_r,
	input wire logic bnd_init_r,
	input wire logic entry_fail_r
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire mi = bi_valid && bi_mem;
	wire m64 = cpu_mode == 2'h2;
	wire udx = cpu_mode == 2'h1 ? bi_pfx67 : cpu_mode == 2'h0 && !bi_pfx67;
	// far forms and short jump
	wire far = br_op0 == 8'heb || br_op0 == 8'hea || br_op0 == 8'h9a || br_op0[7:1] == 7'h65
		|| br_op0 == 8'hff && (br_op1[5:3] == 3'h3 || br_op1[5:3] == 3'h5);
	a_wide_mode: assert property (mi && m64 |=> !ud_fault_r && addr64_r)
		else $error("wide mode op misdecoded");
	a_ud_table: assert property (mi |=> ud_fault_r == $past(udx))
		else $error("address size fault wrong");
	a_addr_narrow: assert property (mi && !m64 && !udx |=> !addr64_r)
		else $error("narrow mode used wide address");
	a_reg_form: assert property (bi_valid && !bi_mem |=> !ud_fault_r)
		else $error("register form faulted");
	a_far_keep: assert property (br_valid && far |=> !bnd_init_r)
		else $error("far branch cleared bounds");
	a_pfx_keep: assert property (br_valid && br_op0 == 8'hf2 |=> !bnd_init_r)
		else $error("prefixed branch cleared bounds");
	a_init_cause: assert property (bnd_init_r |-> $past(br_valid) && !$past(far))
		else $error("bounds cleared without branch");
	a_ud_cause: assert property (ud_fault_r |-> $past(mi))
		else $error("fault without memory form");
	a_fail_cause: assert property (entry_fail_r |-> $past(vm_entry))
		else $error("entry failure without entry");
endmodule
bind bmb_ctrl bmb_ctrl_monitor u_mon (.*);
`default_nettype wire

// File: bench/test_bmb_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module test_bmb_ctrl;
	// ----
	// signals
	// ----
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [1:0] cpu_mode = 0, current_privilege_level = 0, bi_idx = 0;
	logic bi_valid = 0, bi_mem = 0, bi_pfx67 = 0, bi_wr = 0, bi_xstate = 0, br_valid = 0;
	logic [63:0] bi_lb = 0, bi_ub = 0;
	logic [7:0] br_op0 = 0, br_op1 = 0, br_op2 = 0;
	logic rc_fault = 0, system_management_interrupt = 0, resume_from_management = 0, vm_exit = 0, vm_entry = 0;
	logic ud_fault_r, addr64_r, bnd_init_r, entry_fail_r;
	int n_errors = 0, checks_done = 0;
	localparam logic [63:0] V = 64'h12345678_9abcdef0;
	logic [23:0] cov [10] = '{24'he80000, 24'hff1000, 24'hc20000, 24'hc30000, 24'he90000,
		24'hff2000, 24'h700000, 24'h7f0000, 24'h0f8000, 24'h0f8f00};
	logic [15:0] far [7] = '{16'heb00, 16'hea00, 16'h9a00, 16'hca00, 16'hcb00, 16'hff18, 16'hff28};
	bmb_ctrl DUT (.*);
	always #25 aclk = ~aclk;
	// ----
	// helpers
	// ----
	task chk(input [63:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!(s_axi_bvalid && s_axi_bready));
		chk(s_axi_bresp, er);
	endtask
	task rd(input [7:0] a, input [31:0] e, input [1:0] er);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!(s_axi_rvalid && s_axi_rready));
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
	endtask
	// pulses stand one cycle; outputs read at the next edge
	task step;
		@(posedge aclk);
		{bi_valid, br_valid, rc_fault, system_management_interrupt, resume_from_management, vm_exit, vm_entry} <= 0;
		@(posedge aclk);
	endtask
	task ev(input [4:0] k);
		{rc_fault, system_management_interrupt, resume_from_management, vm_exit, vm_entry} <= k;
		step;
	endtask
	task bi(input [1:0] m, input mm, p, w, x, input [63:0] v);
		{cpu_mode, bi_mem, bi_pfx67, bi_wr, bi_xstate} <= {m, mm, p, w, x};
		bi_lb <= v;
		bi_ub <= ~v;
		bi_valid <= 1;
		step;
	endtask
	task br(input [7:0] a, b, c, input e);
		{br_op0, br_op1, br_op2, br_valid} <= {a, b, c, 1'b1};
		step;
		chk(bnd_init_r, e);
	endtask
	// ----
	// scenarios
	// ----
	task t_regs;
		rd(8'h00, 0, 0);
		rd(8'h08, 0, 0);
		rd(8'h28, 0, 0);
		rd(8'h2c, 32'h7ed00000, 0);
		rd(8'h30, 0, 2);
		wr(8'h30, 1, 2);
		wr(8'h2c, 1, 2);
		$display("register test done");
	endtask
	task t_mode;
		bit e;
		for (int m = 0; m < 3; m++)
			for (int p = 0; p < 2; p++) begin
				e = m == 1 && p || m == 0 && !p;
				bi(m, 1, p, 0, 0, 0);
				chk(ud_fault_r, e);
				if (!e) chk(addr64_r, m == 2);
			end
		bi(1, 0, 1, 0, 0, 0);
		chk(ud_fault_r, 0);
		bi(2, 0, 0, 1, 0, V);
		rd(8'h44, 32'h12345678, 0);
		bi(1, 0, 0, 1, 0, V);
		rd(8'h44, 0, 0);
		rd(8'h40, 32'h9abcdef0, 0);
		bi(0, 0, 1, 1, 1, V);
		rd(8'h44, 32'h12345678, 0);
		rd(8'h4c, 32'hedcba987, 0);
		$display("mode test done");
	endtask
	task t_branch;
		wr(8'h08, 1, 0);
		wr(8'h00, 3, 0);
		foreach (cov[i]) begin
			bi_idx <= 2'(i % 4);
			bi(2, 0, 0, 1, 0, V);
			br(8'hf2, cov[i][23:16], cov[i][15:8], 0);
			rd(8'h40 + 8'(i % 4 * 16), 32'h9abcdef0, 0);
			br(cov[i][23:16], cov[i][15:8], cov[i][7:0], 1);
			rd(8'h40 + 8'(i % 4 * 16), 0, 0);
			rd(8'h4c + 8'(i % 4 * 16), 0, 0);
		end
		bi_idx <= 0;
		bi(2, 0, 0, 1, 0, V);
		foreach (far[i]) br(far[i][15:8], far[i][7:0], 0, 0);
		wr(8'h08, 3, 0);
		br(8'he8, 0, 0, 0);
		rd(8'h40, 32'h9abcdef0, 0);
		wr(8'h08, 1, 0);
		current_privilege_level <= 3;
		br(8'h70, 0, 0, 0);
		wr(8'h00, 1, 0);
		br(8'h70, 0, 0, 1);
		current_privilege_level <= 0;
		$display("branch test done");
	endtask
	task sc(input [31:0] ct, input [1:0] pl, input [31:0] su, us, input e);
		wr(8'h28, ct, 0);
		wr(8'h08, su, 0);
		wr(8'h00, us, 0);
		wr(8'h10, 32'h5a, 0);
		current_privilege_level <= pl;
		ev(5'h10);
		rd(8'h10, e ? 0 : 32'h5a, 0);
		current_privilege_level <= 0;
	endtask
	task t_status;
		sc(32'h1c, 0, 1, 0, 1);
		sc(32'h18, 0, 1, 0, 0);
		sc(32'h14, 0, 1, 0, 0);
		sc(32'h0c, 0, 1, 0, 0);
		sc(32'h1c, 0, 0, 1, 0);
		sc(32'h1c, 3, 0, 1, 1);
		sc(32'h1c, 3, 1, 0, 0);
		$display("status test done");
	endtask
	task t_smm;
		wr(8'h08, 32'h1003, 0);
		ev(5'h08);
		rd(8'h18, 32'h1003, 0);
		rd(8'h08, 0, 0);
		br(8'he8, 0, 0, 0);
		wr(8'h18, 32'h1ffd, 0);
		wr(8'h1c, 32'h8000, 0);
		ev(5'h04);
		rd(8'h08, 32'h1001, 0);
		rd(8'h0c, 32'hffff8000, 0);
		$display("management test done");
	endtask
	task t_vm;
		wr(8'h0c, 0, 0);
		wr(8'h28, 32'h1c, 0);
		wr(8'h08, 32'h2001, 0);
		ev(5'h02);
		rd(8'h20, 32'h2001, 0);
		rd(8'h08, 32'h2001, 0);
		wr(8'h28, 32'h1d, 0);
		wr(8'h08, 32'h3001, 0);
		ev(5'h02);
		rd(8'h20, 32'h3001, 0);
		rd(8'h08, 0, 0);
		wr(8'h28, 32'h1c, 0);
		ev(5'h01);
		rd(8'h08, 0, 0);
		wr(8'h28, 32'h1e, 0);
		ev(5'h01);
		chk(entry_fail_r, 0);
		rd(8'h08, 32'h3001, 0);
		wr(8'h20, 32'h3005, 0);
		ev(5'h01);
		chk(entry_fail_r, 1);
		rd(8'h08, 32'h3001, 0);
		$display("vm test done");
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		t_regs;
		t_mode;
		t_branch;
		t_status;
		t_smm;
		t_vm;
		close_out;
	end
	initial begin
		#400000;
		n_errors++;
		close_out;
	end
endmodule
`default_nettype wire
